// ### pfc_front_end.sv
/*
 * Instruction fetch front end: a one-stage fetch/execute pipeline, a
 * sixteen-word circular instruction cache, program and data memory address
 * sourcing from the sequencer, two address generators or the instruction,
 * and the exchange path between the two data buses.
 * Assumes external memories answer in the cycle the address is presented
 * and that the sequencer and decode logic drive the control inputs.
 */
// Functional notes
// - Fetch one cycle, execute the next
// - Every instruction loaded from the bus also written to cache
// - Cache holds sixteen instruction words
// - Circular replacement, newest overwrites oldest
// - Program memory data access: cache supplies instruction
// - Cache miss costs one extra fetch cycle
// - Cache runs with no software control
// - Sequencer next address drives program address bus
// - 14-bit program address bus
// - Select output marks instruction or data access
// - 24-bit program data bus
// - 14-bit data address, 16-bit data bus
// - Data address: direct field or generator
// - Program memory data addresses only from generator
// - Generator one data only; two either memory
// - Generators support linear and modulo stepping
// - Exchange path bridges 24 and 16 bit buses
// - Fetch, address, transfers, updates, compute per cycle
`timescale 1ns/1ps
`include "pfc_defs.svh"

module pfc_front_end
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire pfc_pkg::pfc_pm_addr_t next_pc_i,
    input  wire logic                  pm_data_access_i,
    input  wire logic                  pm_data_write_i,
    input  wire logic                  dm_access_i,
    input  wire logic                  dm_write_i,
    input  wire logic                  dm_direct_i,
    input  wire pfc_pkg::pfc_dm_addr_t dm_direct_addr_i,
    input  wire logic                  dm_use_gen_two_i,
    input  wire logic                  gen_one_load_i,
    input  wire logic                  gen_one_step_i,
    input  wire logic                  gen_one_circ_i,
    input  wire pfc_pkg::pfc_dm_addr_t gen_one_modify_i,
    input  wire pfc_pkg::pfc_dm_addr_t gen_one_length_i,
    input  wire logic                  gen_two_load_i,
    input  wire logic                  gen_two_step_i,
    input  wire logic                  gen_two_circ_i,
    input  wire pfc_pkg::pfc_dm_addr_t gen_two_modify_i,
    input  wire pfc_pkg::pfc_dm_addr_t gen_two_length_i,
    input  wire pfc_pkg::pfc_dm_addr_t gen_load_val_i,
    input  wire pfc_pkg::pfc_exch_e    exch_mode_i,
    input  wire pfc_pkg::pfc_pm_data_t pm_wdata_i,
    input  wire pfc_pkg::pfc_dm_data_t dm_wdata_i,
    input  wire pfc_pkg::pfc_pm_data_t prog_mem_data_bus_i,
    input  wire pfc_pkg::pfc_dm_data_t data_mem_data_bus_i,
    output pfc_pkg::pfc_pm_addr_t      prog_mem_addr_bus_o,
    output logic                       pm_data_select_o,
    output pfc_pkg::pfc_pm_data_t      prog_mem_data_bus_o,
    output logic                       prog_mem_data_oe_o,
    output logic                       prog_mem_wr_o,
    output pfc_pkg::pfc_dm_addr_t      dm_addr_bus_o,
    output pfc_pkg::pfc_dm_data_t      data_mem_data_bus_o,
    output logic                       data_mem_data_oe_o,
    output logic                       dm_rd_o,
    output logic                       dm_wr_o,
    output pfc_pkg::pfc_pm_data_t      insn_o,
    output logic                       insn_valid_o,
    output logic                       stall_o,
    output logic                       cache_hit_o,
    output pfc_pkg::pfc_dm_data_t      exch_dm_o,
    output pfc_pkg::pfc_pm_data_t      exch_pm_o
);
    import pfc_pkg::*;

    // Cache arrays; tags and valid bits stop an unfilled word hitting; program writes do not update them.
    pfc_pm_data_t cache_word [`PFC_CACHE_WORDS];
    pfc_pm_addr_t cache_tag  [`PFC_CACHE_WORDS];
    logic [`PFC_CACHE_WORDS-1:0] cache_valid;
    logic [`PFC_CACHE_IDX_W-1:0] wr_ptr;

    pfc_state_e   state;
    pfc_state_e   next_state;
    pfc_pm_addr_t fetch_addr;
    pfc_pm_addr_t next_fetch_addr;
    logic         fetch_pending;
    logic         next_fetch_pending;

    pfc_dm_addr_t gen_one_addr;
    pfc_dm_addr_t gen_two_addr;

    logic         hit;
    pfc_pm_data_t hit_word;
    logic         load_ir;
    pfc_pm_data_t ir_src;
    logic         write_cache;

    pfc_pm_addr_t next_pm_addr;
    logic         next_pm_sel;
    pfc_pm_data_t next_pm_wdata;
    logic         next_pm_oe;
    logic         next_pm_wr;
    pfc_dm_addr_t next_dm_addr;
    pfc_dm_data_t next_dm_wdata;
    logic         next_dm_oe;
    logic         next_dm_rd;
    logic         next_dm_wr;
    pfc_pm_data_t next_insn;
    logic         next_insn_valid;
    logic         next_stall;
    logic         next_hit;
    pfc_dm_data_t next_exch_dm;
    pfc_pm_data_t next_exch_pm;

    // Both generators step in the same cycle as the fetch and transfers.
    pfc_addr_gen u_gen_one
    (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .load_i     (gen_one_load_i),
        .load_val_i (gen_load_val_i),
        .step_i     (gen_one_step_i),
        .modify_i   (gen_one_modify_i),
        .circular_i (gen_one_circ_i),
        .length_i   (gen_one_length_i),
        .addr_o     (gen_one_addr)
    );

    pfc_addr_gen u_gen_two
    (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .load_i     (gen_two_load_i),
        .load_val_i (gen_load_val_i),
        .step_i     (gen_two_step_i),
        .modify_i   (gen_two_modify_i),
        .circular_i (gen_two_circ_i),
        .length_i   (gen_two_length_i),
        .addr_o     (gen_two_addr)
    );

    // Tag lookup against fetch_addr, the address whose fetch the data access displaced.
    always_comb
    begin
        hit      = 1'b0;
        hit_word = `PFC_INSN_NOP;
        for (int i = 0; i < `PFC_CACHE_WORDS; i++)
        begin
            if (cache_valid[i] && cache_tag[i] == fetch_addr)
            begin
                hit      = 1'b1;
                hit_word = cache_word[i];
            end
        end
    end

    // Fetch sequencing. The instruction fetched on a bus cycle enters the
    // instruction register at the edge ending it and executes next cycle.
    always_comb
    begin
        next_state         = state;
        next_fetch_addr    = fetch_addr;
        next_fetch_pending = 1'b0;
        load_ir            = 1'b0;
        ir_src             = prog_mem_data_bus_i;
        write_cache        = 1'b0;
        next_stall         = 1'b0;
        next_hit           = 1'b0;
        next_pm_addr       = next_pc_i;
        next_pm_sel        = 1'b0;
        unique case (state)
            PFC_RUN:
            begin
                if (fetch_pending)
                begin
                    // This cycle's bus carries the fetch at fetch_addr.
                    load_ir     = 1'b1;
                    write_cache = 1'b1;
                end
                next_fetch_addr    = next_pc_i;
                next_fetch_pending = 1'b1;
                if (pm_data_access_i)
                begin
                    // The bus goes to data; instruction must come elsewhere.
                    next_pm_addr       = gen_two_addr;
                    next_pm_sel        = 1'b1;
                    next_fetch_pending = 1'b0;
                    next_state         = PFC_REFETCH;
                end
            end
            PFC_REFETCH:
            begin
                if (hit)
                begin
                    load_ir    = 1'b1;
                    ir_src     = hit_word;
                    next_hit   = 1'b1;
                    next_state = PFC_RUN;
                    next_fetch_addr    = next_pc_i;
                    next_fetch_pending = 1'b1;
                    if (pm_data_access_i)
                    begin
                        next_pm_addr       = gen_two_addr;
                        next_pm_sel        = 1'b1;
                        next_fetch_pending = 1'b0;
                        next_state         = PFC_REFETCH;
                    end
                end
                else
                begin
                    // Miss: one extra bus cycle for the instruction.
                    next_pm_addr       = fetch_addr;
                    next_stall         = 1'b1;
                    next_fetch_pending = 1'b1;
                    next_state         = PFC_RUN;
                end
            end
            default:
            begin
                next_state = PFC_RUN;
            end
        endcase
        next_insn       = load_ir ? ir_src : insn_o;
        next_insn_valid = load_ir;
    end

    // Data paths, addressing and the exchange unit.
    always_comb
    begin
        next_pm_wdata = pm_wdata_i;
        next_pm_oe    = pm_data_access_i && pm_data_write_i
                        && state == PFC_RUN;
        next_pm_wr    = next_pm_oe;
        // Generator one never reaches program memory.
        next_dm_addr  = dm_direct_i ? dm_direct_addr_i
                      : (dm_use_gen_two_i ? gen_two_addr
                                          : gen_one_addr);
        next_dm_wdata = dm_wdata_i;
        next_dm_oe    = dm_access_i && dm_write_i;
        next_dm_rd    = dm_access_i && !dm_write_i;
        next_dm_wr    = next_dm_oe;
        next_exch_dm  = exch_dm_o;
        next_exch_pm  = exch_pm_o;
        // The upper 16 bits carry the word; the low 8 pad with zero.
        unique case (exch_mode_i)
            PFC_EXCH_NONE:
            begin
            end
            PFC_EXCH_PM_TO_DM:
            begin
                next_exch_dm = prog_mem_data_bus_i[`PFC_PM_DATA_W-1 -:
                                                   `PFC_DM_DATA_W];
            end
            PFC_EXCH_DM_TO_PM:
            begin
                next_exch_pm = {data_mem_data_bus_i,
                                {`PFC_EXCH_DIFF_W{1'b0}}};
            end
            default:
            begin
            end
        endcase
    end

    // Cache fill needs no software; it tracks every instruction load from the bus, not cache hits.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cache_valid <= '0;
            wr_ptr      <= '0;
        end
        else if (write_cache)
        begin
            cache_valid[wr_ptr] <= 1'b1;
            wr_ptr              <= wr_ptr + 1'b1;
        end
    end

    // Word and tag storage has no reset; the valid bits guard it.
    always_ff @(posedge clk_i)
    begin
        if (write_cache)
        begin
            cache_word[wr_ptr] <= ir_src;
            cache_tag[wr_ptr]  <= fetch_addr;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state               <= PFC_RUN;
            fetch_addr          <= `PFC_PC_RESET;
            fetch_pending       <= 1'b0;
            prog_mem_addr_bus_o <= `PFC_PC_RESET;
            pm_data_select_o    <= 1'b0;
            prog_mem_data_bus_o <= '0;
            prog_mem_data_oe_o  <= 1'b0;
            prog_mem_wr_o       <= 1'b0;
            dm_addr_bus_o       <= '0;
            data_mem_data_bus_o <= '0;
            data_mem_data_oe_o  <= 1'b0;
            dm_rd_o             <= 1'b0;
            dm_wr_o             <= 1'b0;
            insn_o              <= `PFC_INSN_NOP;
            insn_valid_o        <= 1'b0;
            stall_o             <= 1'b0;
            cache_hit_o         <= 1'b0;
            exch_dm_o           <= '0;
            exch_pm_o           <= '0;
        end
        else
        begin
            state               <= next_state;
            fetch_addr          <= next_fetch_addr;
            fetch_pending       <= next_fetch_pending;
            prog_mem_addr_bus_o <= next_pm_addr;
            pm_data_select_o    <= next_pm_sel;
            prog_mem_data_bus_o <= next_pm_wdata;
            prog_mem_data_oe_o  <= next_pm_oe;
            prog_mem_wr_o       <= next_pm_wr;
            dm_addr_bus_o       <= next_dm_addr;
            data_mem_data_bus_o <= next_dm_wdata;
            data_mem_data_oe_o  <= next_dm_oe;
            dm_rd_o             <= next_dm_rd;
            dm_wr_o             <= next_dm_wr;
            insn_o              <= next_insn;
            insn_valid_o        <= next_insn_valid;
            stall_o             <= next_stall;
            cache_hit_o         <= next_hit;
            exch_dm_o           <= next_exch_dm;
            exch_pm_o           <= next_exch_pm;
        end
    end
endmodule

// ### pfc_defs.svh
/*
 * Constants for the program fetch and cache front end: bus widths, cache
 * geometry, reset values and exchange lane layout.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

`define PFC_PM_ADDR_W   14
`define PFC_PM_DATA_W   24
`define PFC_DM_ADDR_W   14
`define PFC_DM_DATA_W   16
`define PFC_EXCH_DIFF_W 8
`define PFC_CACHE_WORDS 16
`define PFC_CACHE_IDX_W 4
`define PFC_PC_RESET    14'h0000
`define PFC_INSN_NOP    24'h000000

`endif

// ### pfc_pkg.sv
/*
 * Types shared by the fetch front end and its address generator.
 * Assumes pfc_defs.svh is on the include path.
 */
`include "pfc_defs.svh"

package pfc_pkg;
    typedef logic [`PFC_PM_ADDR_W-1:0] pfc_pm_addr_t;
    typedef logic [`PFC_PM_DATA_W-1:0] pfc_pm_data_t;
    typedef logic [`PFC_DM_ADDR_W-1:0] pfc_dm_addr_t;
    typedef logic [`PFC_DM_DATA_W-1:0] pfc_dm_data_t;

    // Bus cycle kind of the front end.
    typedef enum logic [1:0]
    {
        PFC_RUN,
        PFC_REFETCH
    } pfc_state_e;

    // Exchange path mode between program data bus and data memory bus.
    typedef enum logic [1:0]
    {
        PFC_EXCH_NONE,
        PFC_EXCH_PM_TO_DM,
        PFC_EXCH_DM_TO_PM
    } pfc_exch_e;
endpackage

// ### pfc_addr_gen.sv
/*
 * One data address generator: an index register stepped by a signed
 * modifier, either linearly or wrapped inside a circular buffer of a given
 * length whose base is the loaded index itself.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`include "pfc_defs.svh"

module pfc_addr_gen
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 load_i,
    input  wire pfc_pkg::pfc_dm_addr_t load_val_i,
    input  wire logic                 step_i,
    input  wire pfc_pkg::pfc_dm_addr_t modify_i,
    input  wire logic                 circular_i,
    input  wire pfc_pkg::pfc_dm_addr_t length_i,
    output logic                      [`PFC_DM_ADDR_W-1:0] addr_o
);
    import pfc_pkg::*;

    pfc_dm_addr_t index;
    pfc_dm_addr_t base;
    pfc_dm_addr_t next_index;
    pfc_dm_addr_t next_base;
    pfc_dm_addr_t stepped;
    pfc_dm_addr_t top;

    always_comb
    begin
        next_index = index;
        next_base  = base;
        stepped    = pfc_dm_addr_t'(index + modify_i);
        top        = pfc_dm_addr_t'(base + length_i);
        if (load_i)
        begin
            next_index = load_val_i;
            next_base  = load_val_i;
        end
        else if (step_i)
        begin
            // Wrap keeps the pointer within base .. base+length-1.
            if (circular_i && length_i != '0)
            begin
                if (modify_i[`PFC_DM_ADDR_W-1] && stepped < base)
                    next_index = pfc_dm_addr_t'(stepped + length_i);
                else if (!modify_i[`PFC_DM_ADDR_W-1] && stepped >= top)
                    next_index = pfc_dm_addr_t'(stepped - length_i);
                else
                    next_index = stepped;
            end
            else
            begin
                next_index = stepped;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            index <= '0;
            base  <= '0;
        end
        else
        begin
            index <= next_index;
            base  <= next_base;
        end
    end

    assign addr_o = index;
endmodule

// ### pfc_front_end_props.sv
/*
 * Checker for the fetch front end, bound to its top module ports.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps

module pfc_front_end_chk
(
    input wire logic                  clk_i,
    input wire logic                  rst_b_i,
    input wire pfc_pkg::pfc_pm_addr_t next_pc_i,
    input wire logic                  pm_data_access_i,
    input wire logic                  pm_data_write_i,
    input wire pfc_pkg::pfc_pm_data_t prog_mem_data_bus_i,
    input wire pfc_pkg::pfc_pm_addr_t prog_mem_addr_bus_o,
    input wire logic                  pm_data_select_o,
    input wire logic                  prog_mem_data_oe_o,
    input wire logic                  prog_mem_wr_o,
    input wire pfc_pkg::pfc_pm_data_t insn_o,
    input wire logic                  insn_valid_o,
    input wire logic                  stall_o,
    input wire logic                  cache_hit_o
);
    import pfc_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_addr_follows_pc: assert property (
        !$past(pm_data_access_i) && !$past(pm_data_access_i, 2)
        |-> prog_mem_addr_bus_o == $past(next_pc_i))
        else $error("address bus lost the next address");
    // A select already high marks a refetch cycle, where writes are refused.
    a_pm_data_write: assert property (
        pm_data_access_i && pm_data_write_i && !pm_data_select_o
        |=> pm_data_select_o && prog_mem_wr_o && prog_mem_data_oe_o)
        else $error("program data write not driven");
    a_pm_data_read: assert property (
        pm_data_access_i && !pm_data_write_i && !pm_data_select_o
        |=> pm_data_select_o && !prog_mem_data_oe_o && !prog_mem_wr_o)
        else $error("program data read not marked");
    a_insn_from_bus: assert property (
        insn_valid_o && !cache_hit_o |-> insn_o == $past(prog_mem_data_bus_i))
        else $error("instruction differs from fetched word");
    // The first cycle out of reset has no fetch behind it yet.
    a_fetch_loads: assert property (
        $past(rst_b_i) && !pm_data_select_o && !stall_o |=> insn_valid_o)
        else $error("fetch did not load the instruction");
    a_hit_or_stall: assert property (
        pm_data_select_o |=> cache_hit_o != stall_o)
        else $error("data cycle not followed by hit or stall");
    a_stall_one_cycle: assert property (
        stall_o |=> !stall_o && insn_valid_o && !cache_hit_o)
        else $error("refetch took more than one cycle");
    a_hit_loads_insn: assert property (
        cache_hit_o |-> insn_valid_o && !stall_o)
        else $error("cache hit without instruction load");
endmodule

bind pfc_front_end pfc_front_end_chk pfc_front_end_chk_i
(
    .clk_i(clk_i), .rst_b_i(rst_b_i), .next_pc_i(next_pc_i),
    .pm_data_access_i(pm_data_access_i), .pm_data_write_i(pm_data_write_i),
    .prog_mem_data_bus_i(prog_mem_data_bus_i),
    .prog_mem_addr_bus_o(prog_mem_addr_bus_o),
    .pm_data_select_o(pm_data_select_o),
    .prog_mem_data_oe_o(prog_mem_data_oe_o), .prog_mem_wr_o(prog_mem_wr_o),
    .insn_o(insn_o), .insn_valid_o(insn_valid_o), .stall_o(stall_o),
    .cache_hit_o(cache_hit_o)
);

// ### pfc_mem_model.sv
/*
 * Program and data memories on the far side of the front end.
 * Assumes reads answer in the cycle the address is shown.
 */
`timescale 1ns/1ps

module pfc_mem_model
(
    input  wire pfc_pkg::pfc_pm_addr_t pm_addr_i,
    input  wire pfc_pkg::pfc_pm_data_t pm_wdata_i,
    input  wire logic                  pm_oe_i,
    output pfc_pkg::pfc_pm_data_t      pm_rdata_o,
    input  wire pfc_pkg::pfc_dm_addr_t dm_addr_i,
    input  wire pfc_pkg::pfc_dm_data_t dm_wdata_i,
    input  wire logic                  dm_oe_i,
    output pfc_pkg::pfc_dm_data_t      dm_rdata_o
);
    import pfc_pkg::*;

    // Contents are a pattern of the address, so no preload is needed.
    // While the front end drives a bus, the wire carries its value.
    assign pm_rdata_o = pm_oe_i ? pm_wdata_i
                                : {10'h2A5, pm_addr_i};
    assign dm_rdata_o = dm_oe_i ? dm_wdata_i : {2'h2, dm_addr_i};
endmodule

// ### pfc_front_end_tb_top.sv
/*
 * Self-checking bench for the fetch front end and its memory models.
 * Assumes the checker file is compiled together with the design.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end

module pfc_front_end_tb_top;
    import pfc_pkg::*;

    localparam pfc_pm_addr_t gen_two_addr = 14'h2345;
    logic         clk_i = 1'b0;
    logic         rst_b_i = 1'b0;
    int           num_checks = 0;
    int           mismatches = 0;
    int           cycles = 0;
    logic         pa, pwr, da, dwr, dd, g2, l1, s1, c1, l2, s2;
    pfc_pm_addr_t pc, paddr;
    pfc_dm_addr_t dda, m1, len1, gv, daddr;
    pfc_pm_data_t pwd, prd, pdout, insn, xpm;
    pfc_dm_data_t dwd, drdat, ddout, xdm;
    pfc_exch_e    exm;
    logic         sel, poe, pwe, doe, drd, dwe, iv, stl, chit;

    pfc_front_end pfc_front_end_i
    (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .next_pc_i(pc),
        .pm_data_access_i(pa), .pm_data_write_i(pwr), .dm_access_i(da),
        .dm_write_i(dwr), .dm_direct_i(dd), .dm_direct_addr_i(dda),
        .dm_use_gen_two_i(g2), .gen_one_load_i(l1), .gen_one_step_i(s1),
        .gen_one_circ_i(c1), .gen_one_modify_i(m1), .gen_one_length_i(len1),
        .gen_two_load_i(l2), .gen_two_step_i(s2), .gen_two_circ_i(c1),
        .gen_two_modify_i(m1), .gen_two_length_i(len1),
        .gen_load_val_i(gv), .exch_mode_i(exm), .pm_wdata_i(pwd),
        .dm_wdata_i(dwd), .prog_mem_data_bus_i(prd),
        .data_mem_data_bus_i(drdat), .prog_mem_addr_bus_o(paddr),
        .pm_data_select_o(sel), .prog_mem_data_bus_o(pdout),
        .prog_mem_data_oe_o(poe), .prog_mem_wr_o(pwe), .dm_addr_bus_o(daddr),
        .data_mem_data_bus_o(ddout), .data_mem_data_oe_o(doe), .dm_rd_o(drd),
        .dm_wr_o(dwe), .insn_o(insn), .insn_valid_o(iv), .stall_o(stl),
        .cache_hit_o(chit), .exch_dm_o(xdm), .exch_pm_o(xpm)
    );

    pfc_mem_model pfc_mem_model_i
    (
        .pm_addr_i(paddr), .pm_wdata_i(pdout), .pm_oe_i(poe),
        .pm_rdata_o(prd), .dm_addr_i(daddr), .dm_wdata_i(ddout),
        .dm_oe_i(doe), .dm_rdata_o(drdat)
    );

    always #12.5 clk_i = ~clk_i;

    // All scenarios together need only about sixty cycles.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            summarize();
        end
    end

    function automatic pfc_pm_data_t pword(input pfc_pm_addr_t a);
        return {10'h2A5, a};
    endfunction

    task automatic cyc(input int n = 1);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    task automatic pm_acc(input pfc_pm_addr_t nxt, input logic hit, wr);
        pa = 1'b1;
        pwr = wr;
        pc = nxt;
        cyc();
        `CHK({sel, pwe, poe}, {1'b1, wr, wr})
        `CHK(paddr, gen_two_addr)
        if (wr) `CHK(pdout, pwd)
        pa = 1'b0;
        pwr = 1'b0;
        pc = nxt + 14'h0001;
        cyc();
        `CHK({chit, stl}, {hit, ~hit})
        if (!hit)
        begin
            `CHK(paddr, nxt)
            cyc();
        end
        `CHK(insn, pword(nxt))
    endtask

    task automatic t_gen_pm;
        gv = gen_two_addr;
        l2 = 1'b1;
        cyc();
        l2 = 1'b0;
        pwd = 24'h5A5A5A;
        pm_acc(14'h0010, 1'b0, 1'b1);
        $display("t_gen_pm done");
    endtask

    task automatic t_fetch;
        pc = 14'h0100;
        cyc();
        for (int i = 1; i < 18; i++)
        begin
            pc = 14'h0100 + 14'(i);
            cyc();
            `CHK(paddr, pc)
            `CHK({iv, insn}, {1'b1, pword(pc - 14'h0001)})
        end
        // Eighteen loads leave only the last sixteen addresses cached.
        pm_acc(14'h0102, 1'b1, 1'b0);
        pm_acc(14'h0100, 1'b0, 1'b0);
        $display("t_fetch done");
    endtask

    task automatic gen_run(input pfc_dm_addr_t v, m, input logic c,
                           input pfc_dm_addr_t len, input int n);
        gv = v;
        m1 = m;
        c1 = c;
        len1 = len;
        l1 = 1'b1;
        cyc();
        l1 = 1'b0;
        s1 = 1'b1;
        cyc(n);
        s1 = 1'b0;
        cyc(2);
    endtask

    task automatic t_dm;
        da = 1'b1;
        dd = 1'b1;
        dda = 14'h1234;
        cyc();
        `CHK({daddr, drd, dwe, doe}, {14'h1234, 3'b100})
        dwr = 1'b1;
        dwd = 16'hBEEF;
        cyc();
        `CHK({drd, dwe, doe, ddout}, {3'b011, 16'hBEEF})
        dwr = 1'b0;
        dd = 1'b0;
        gen_run(14'h0100, 14'h0003, 1'b0, 14'h0000, 2);
        `CHK(daddr, 14'h0106)
        gen_run(14'h0040, 14'h0001, 1'b1, 14'h0004, 4);
        `CHK(daddr, 14'h0040)
        g2 = 1'b1;
        cyc(2);
        `CHK(daddr, gen_two_addr)
        // Generator two shares modifier and length lines with generator one.
        s2 = 1'b1;
        cyc();
        s2 = 1'b0;
        cyc(2);
        `CHK(daddr, gen_two_addr + 14'h0001)
        g2 = 1'b0;
        $display("t_dm done");
    endtask

    task automatic t_exch;
        pfc_pm_data_t w;
        w = pword(14'h0155);
        exm = PFC_EXCH_PM_TO_DM;
        pc = 14'h0155;
        cyc(3);
        `CHK(xdm, w[23:8])
        exm = PFC_EXCH_DM_TO_PM;
        dd = 1'b1;
        cyc(3);
        `CHK(xpm, {2'h2, 14'h1234, 8'h00})
        $display("t_exch done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        {pa, pwr, da, dwr, dd, g2, l1, s1, c1, l2, s2} = '0;
        {pc, dda, m1, len1, gv, pwd, dwd} = '0;
        exm = PFC_EXCH_NONE;
        cyc(6);
        `CHK({paddr, iv, stl, chit}, '0)
        rst_b_i = 1'b1;
        t_gen_pm();
        t_fetch();
        t_dm();
        t_exch();
        summarize();
    end
endmodule
